/* hdl/pioxb_pkg.sv */
// Package: constants for the port pin cells and crossbar.
package pioxb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 21;
  localparam int unsigned NUM_XBAR_PINS = 20;
  localparam int unsigned NUM_SLOTS = 16;
  localparam int unsigned NUM_PORTS = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_DATA = 8'h00;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h0C;
  localparam logic [7:0] OFS_OUT_MODE = 8'h18;
  localparam logic [7:0] OFS_SKIP_MASK = 8'h24;
  localparam logic [7:0] OFS_RES_SEL_A = 8'h30;
  localparam logic [7:0] OFS_RES_SEL_B = 8'h34;
  localparam logic [7:0] OFS_LAST = 8'h34;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Resource select A bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SELA_UART = 0;
  localparam int unsigned SELA_SPI = 1;
  localparam int unsigned SELA_SMB = 2;
  localparam int unsigned SELA_CMP = 3;
  localparam int unsigned SELA_SYSCLK = 4;

  // ----------------------------------------------------------------
  // Resource select B bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SELB_CAP_LO = 0;
  localparam int unsigned SELB_CNT_IN = 3;
  localparam int unsigned SELB_T0 = 4;
  localparam int unsigned SELB_T1 = 5;
  localparam int unsigned SELB_PU_DIS = 6;
  localparam int unsigned SELB_XBAR_EN = 7;

  // ----------------------------------------------------------------
  // Fixed pins of the serial port, and the AXI answers
  // ----------------------------------------------------------------
  localparam logic [4:0] UART_TX_PIN = 5'h04;
  localparam logic [4:0] UART_RX_PIN = 5'h05;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pioxb_pkg

/* hdl/pioxb_top.sv */
// Port pin cells, priority crossbar and their AXI4-Lite register file.
// Behaviour
// - Reset: all cells high impedance, pull-ups on.
// - Crossbar disabled: crossbar pin drivers all off.
// - Analog-select bit 1 puts cell analog, except on the GPIO-only pin.
// - Analog cell: pull-up, driver, receiver off.
// - Analog pin reads back as zero.
// - Push-pull digital pin drives high and low.
// - Open-drain pin never drives high.
// - High-impedance digital cell enables weak pull-up.
// - Pull-up off while cell drives low.
// - Global disable bit kills all pull-ups.
// - Digital pin reads sensed pad level.
// - Port read shows pins regardless of crossbar.
// - Crossbar routes selected resources by priority.
// - Twenty crossbar pins plus one GPIO-only pin.
// - Each resource but the serial port takes lowest free unskipped pin.
// - Serial port fixed on P0.4 and P0.5.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pioxb_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pioxb_pkg::NUM_PINS-1:0] pad_i,
  output logic [pioxb_pkg::NUM_PINS-1:0] pad_o,
  output logic [pioxb_pkg::NUM_PINS-1:0] pad_oe,
  output logic [pioxb_pkg::NUM_PINS-1:0] pad_pullup_en,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_out,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_drive,
  output logic [pioxb_pkg::NUM_SLOTS-1:0] periph_in,
  output logic [pioxb_pkg::NUM_SLOTS-1:0] periph_routed
);

  localparam int unsigned NP = pioxb_pkg::NUM_PINS;
  localparam int unsigned NX = pioxb_pkg::NUM_XBAR_PINS;
  localparam int unsigned NS = pioxb_pkg::NUM_SLOTS;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [23:0] latch_q;
  logic [23:0] analog_q;
  logic [23:0] outmode_q;
  logic [23:0] skip_q;
  logic [7:0] sel_a_q;
  logic [7:0] sel_b_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane0_q;
  logic do_write;
  logic [7:0] wr_ofs;
  logic wr_hit;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ofs = 8'(awaddr_q);
  assign wr_hit = (wr_ofs <= pioxb_pkg::OFS_LAST) && (wr_ofs[1:0] == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pioxb_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? pioxb_pkg::RESP_OKAY : pioxb_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Registers are eight bits wide; only byte lane 0 carries data.
  logic wr_en;
  logic [3:0] wr_idx;
  logic [1:0] wr_port;
  logic [4:0] wr_bit;

  assign wr_en = do_write && wr_hit && wlane0_q;
  assign wr_idx = wr_ofs[5:2];
  assign wr_port = (wr_idx >= 4'h9) ? 2'(wr_idx - 4'h9) :
                   (wr_idx >= 4'h6) ? 2'(wr_idx - 4'h6) :
                   (wr_idx >= 4'h3) ? 2'(wr_idx - 4'h3) : 2'(wr_idx);
  assign wr_bit = {wr_port, 3'h0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_q <= {3{pioxb_pkg::RST_LATCH}};
      analog_q <= {3{pioxb_pkg::RST_ZERO}};
      outmode_q <= {3{pioxb_pkg::RST_ZERO}};
      skip_q <= {3{pioxb_pkg::RST_ZERO}};
      sel_a_q <= pioxb_pkg::RST_ZERO;
      sel_b_q <= pioxb_pkg::RST_ZERO;
    end
    else if (wr_en)
    begin
      if (wr_idx < 4'h3)
        latch_q[wr_bit +: 8] <= wdata_q;
      else if (wr_idx < 4'h6)
        analog_q[wr_bit +: 8] <= wdata_q;
      else if (wr_idx < 4'h9)
        outmode_q[wr_bit +: 8] <= wdata_q;
      else if (wr_idx < 4'hC)
        skip_q[wr_bit +: 8] <= wdata_q;
      else if (wr_idx == 4'hC)
        sel_a_q <= wdata_q;
      else
        sel_b_q <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Crossbar priority decoder
  // ----------------------------------------------------------------
  logic xbar_en;
  logic pu_dis;
  logic [NS-1:0] slot_en;
  logic [NS-1:0] slot_ok;
  logic [4:0] slot_pin [NS];
  logic [NX-1:0] taken;
  logic found;

  assign xbar_en = sel_b_q[pioxb_pkg::SELB_XBAR_EN];
  assign pu_dis = sel_b_q[pioxb_pkg::SELB_PU_DIS];
  assign slot_en[1:0] = {2{sel_a_q[pioxb_pkg::SELA_UART]}};
  assign slot_en[5:2] = {4{sel_a_q[pioxb_pkg::SELA_SPI]}};
  assign slot_en[7:6] = {2{sel_a_q[pioxb_pkg::SELA_SMB]}};
  assign slot_en[8] = sel_a_q[pioxb_pkg::SELA_CMP];
  assign slot_en[9] = sel_a_q[pioxb_pkg::SELA_SYSCLK];
  assign slot_en[10] = sel_b_q[2:0] >= 3'h1;
  assign slot_en[11] = sel_b_q[2:0] >= 3'h2;
  assign slot_en[12] = sel_b_q[2:0] >= 3'h3;
  assign slot_en[13] = sel_b_q[pioxb_pkg::SELB_CNT_IN];
  assign slot_en[14] = sel_b_q[pioxb_pkg::SELB_T0];
  assign slot_en[15] = sel_b_q[pioxb_pkg::SELB_T1];

  // Slot order is the priority order; the serial port is placed first
  // and outside the search, so skip bits cannot move it.
  always_comb
  begin
    taken = '0;
    slot_ok = '0;
    found = 1'b0;
    for (int s = 0; s < NS; s++)
      slot_pin[s] = 5'h00;
    if (slot_en[0])
    begin
      slot_pin[0] = pioxb_pkg::UART_TX_PIN;
      slot_pin[1] = pioxb_pkg::UART_RX_PIN;
      slot_ok[1:0] = 2'h3;
      taken[pioxb_pkg::UART_TX_PIN] = 1'b1;
      taken[pioxb_pkg::UART_RX_PIN] = 1'b1;
    end
    for (int s = 2; s < NS; s++)
    begin
      found = 1'b0;
      if (slot_en[s])
      begin
        for (int p = 0; p < NX; p++)
        begin
          if (!found && !taken[p] && !skip_q[p])
          begin
            slot_pin[s] = 5'(p);
            slot_ok[s] = 1'b1;
            taken[p] = 1'b1;
            found = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  logic [NP-1:0] pin_val;
  logic [NP-1:0] pin_analog;
  logic [NP-1:0] drv_lo;
  logic [NP-1:0] drv_hi;
  logic [NP-1:0] pin_read;

  // A routed input-only function offers a one, which releases the pad only in open-drain mode.
  always_comb
  begin
    pin_val = latch_q[NP-1:0];
    for (int p = 0; p < NX; p++)
      for (int s = 0; s < NS; s++)
        if (slot_ok[s] && slot_pin[s] == 5'(p))
        begin
          pin_val[p] = !periph_drive[s] || periph_out[s];
        end
  end

  // The last pin is GPIO only and never analog, nor gated by the crossbar.
  assign pin_analog = {1'b0, analog_q[NX-1:0]};
  assign drv_lo[NX-1:0] = {NX{xbar_en}} & ~pin_analog[NX-1:0]
                          & ~pin_val[NX-1:0];
  assign drv_hi[NX-1:0] = {NX{xbar_en}} & ~pin_analog[NX-1:0]
                          & outmode_q[NX-1:0] & pin_val[NX-1:0];
  assign drv_lo[NP-1] = !pin_val[NP-1];
  assign drv_hi[NP-1] = outmode_q[NP-1] && pin_val[NP-1];
  assign pin_read = pad_i & ~pin_analog;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_o <= '0;
      pad_oe <= '0;
      pad_pullup_en <= '1;
    end
    else
    begin
      pad_o <= drv_hi;
      pad_oe <= drv_hi | drv_lo;
      pad_pullup_en <= ~pin_analog & ~drv_lo & {NP{!pu_dis}};
    end
  end

  // Routed inputs see the sensed pad; analog cells give zero.
  always_comb
  begin
    periph_in = '0;
    for (int s = 0; s < NS; s++)
      if (slot_ok[s] && xbar_en)
        periph_in[s] = pin_read[slot_pin[s]];
  end
  assign periph_routed = slot_ok & {NS{xbar_en}};

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_ofs;
  logic [3:0] rd_idx;
  logic [1:0] rd_port;
  logic [4:0] rd_bit;
  logic rd_hit;
  logic [23:0] rd_vec;
  logic [7:0] rd_byte;
  logic [23:0] pin_read_wide;

  assign rd_ofs = 8'(s_axi_araddr);
  assign rd_idx = rd_ofs[5:2];
  assign rd_hit = (rd_ofs <= pioxb_pkg::OFS_LAST) && (rd_ofs[1:0] == 2'h0);
  assign rd_port = (rd_idx >= 4'h9) ? 2'(rd_idx - 4'h9) :
                   (rd_idx >= 4'h6) ? 2'(rd_idx - 4'h6) :
                   (rd_idx >= 4'h3) ? 2'(rd_idx - 4'h3) : 2'(rd_idx);
  assign rd_bit = {rd_port, 3'h0};
  assign pin_read_wide = {3'h0, pin_read};
  assign rd_vec = (rd_idx < 4'h3) ? pin_read_wide :
                  (rd_idx < 4'h6) ? analog_q :
                  (rd_idx < 4'h9) ? outmode_q : skip_q;
  assign rd_byte = (rd_idx == 4'hC) ? sel_a_q :
                   (rd_idx == 4'hD) ? sel_b_q : rd_vec[rd_bit +: 8];
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pioxb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp <= rd_hit ? pioxb_pkg::RESP_OKAY : pioxb_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pioxb_top

`default_nettype wire

/* tb/pioxb_properties.sv */
// Checker: port-level properties of the pin cells and crossbar.
`timescale 1ns/1ps
`default_nettype none
module pioxb_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [pioxb_pkg::NUM_PINS-1:0] pad_i,
  input wire logic [pioxb_pkg::NUM_PINS-1:0] pad_o,
  input wire logic [pioxb_pkg::NUM_PINS-1:0] pad_oe,
  input wire logic [pioxb_pkg::NUM_PINS-1:0] pad_pullup_en,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_out,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_drive,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_in,
  input wire logic [pioxb_pkg::NUM_SLOTS-1:0] periph_routed
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_release:
    assert property ($rose(aresetn) |-> pad_oe == 21'h0 && &pad_pullup_en)
    else $error("pins not released with pull-ups after reset");
  a_low_no_pullup:
    assert property ((pad_oe & ~pad_o & pad_pullup_en) == 21'h0)
    else $error("pull-up on while driving low");
  a_high_needs_drive:
    assert property ((pad_o & ~pad_oe) == 21'h0)
    else $error("high value without driver enable");
  a_unrouted_quiet:
    assert property ((periph_in & ~periph_routed) == 16'h0)
    else $error("unrouted slot sees a pad");
  a_uart_pair:
    assert property (periph_routed[0] == periph_routed[1])
    else $error("serial lines routed apart");
  a_uart_rx_pin:
    assert property (periph_in[1] |-> pad_i[5])
    else $error("serial receive not from pin 5");
  a_uart_tx_drive:
    assert property (periph_routed[0] && periph_drive[0] && !periph_out[0]
      |=> pad_oe[4] && !pad_o[4])
    else $error("serial transmit low not on pin 4");
  a_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule : pioxb_properties
bind pioxb_top pioxb_properties u_chk (.*);
`default_nettype wire

/* tb/pioxb_board.sv */
// Board model: resolves each pad from the cell, an external driver and the pull-up.
`timescale 1ns/1ps
`default_nettype none
module pioxb_board #(
  parameter int unsigned N = pioxb_pkg::NUM_PINS
) (
  input wire logic aclk,
  input wire logic [N-1:0] pad_o,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup_en,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad_i
);
  // A floating pad shows the inverse of its last level, so no stale level passes for a real one.
  logic [N-1:0] float_q;
  always_ff @(posedge aclk) float_q <= ~pad_i;
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pullup_en | float_q));
endmodule : pioxb_board
`default_nettype wire

/* tb/test_port_io_cell_and_crossbar.sv */
// Testbench: register bus, pin modes and crossbar routing.
`timescale 1ns/1ps
`default_nettype none
module test_port_io_cell_and_crossbar;
  logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rdv;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [20:0] pad_i, pad_o, pad_oe, pad_pullup_en, ext_en = 21'h0, ext_val = 21'h0;
  logic [15:0] periph_out = 16'h0, periph_drive = 16'h0, periph_in, periph_routed;
  int fail_count = 0;
  int tests_run = 0;
  pioxb_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pad_i, .pad_o, .pad_oe, .pad_pullup_en, .periph_out,
    .periph_drive, .periph_in, .periph_routed);
  pioxb_board board (.aclk, .pad_o, .pad_oe, .pad_pullup_en, .ext_en, .ext_val, .pad_i);
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // The response is left waiting one cycle so that its hold is exercised.
    s_axi_bready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Pads follow a register store one edge later, so two edges are ample.
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle
  task automatic t_reset;
    #1;
    chk(32'(pad_oe), 32'h0);
    chk(32'(pad_pullup_en), 32'h1FFFFF);
    rd(pioxb_pkg::OFS_PORT_DATA);
    chk(32'(rdv), 32'hFF);
    $display("reset test done");
  endtask : t_reset
  task automatic t_analog;
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b1;
    wr(pioxb_pkg::OFS_ANALOG_SEL, 8'h01);
    settle();
    chk(32'({pad_oe[0], pad_pullup_en[0]}), 32'h0);
    rd(pioxb_pkg::OFS_PORT_DATA);
    chk(32'(rdv), 32'hFE);
    wr(pioxb_pkg::OFS_ANALOG_SEL, 8'h00);
    ext_val[0] <= 1'b0;
    settle();
    chk(32'(pad_pullup_en[0]), 32'h1);
    rd(pioxb_pkg::OFS_PORT_DATA);
    chk(32'(rdv), 32'hFE);
    ext_en[0] <= 1'b0;
    $display("analog test done");
  endtask : t_analog
  task automatic t_drive;
    wr(pioxb_pkg::OFS_PORT_DATA, 8'h00);
    wr(pioxb_pkg::OFS_PORT_DATA + 8'h08, 8'h0F);
    settle();
    chk(32'(pad_oe), 32'h100000);
    wr(pioxb_pkg::OFS_RES_SEL_B, 8'h80);
    settle();
    chk(32'({pad_oe[7:0], pad_o[7:0], pad_pullup_en[7:0]}), 32'hFF0000);
    wr(pioxb_pkg::OFS_PORT_DATA, 8'hFF);
    wr(pioxb_pkg::OFS_OUT_MODE, 8'h01);
    settle();
    chk(32'({pad_oe[7:0], pad_o[7:0], pad_pullup_en[7:1]}), 32'h80FF);
    wr(pioxb_pkg::OFS_RES_SEL_B, 8'hC0);
    settle();
    chk(32'(pad_pullup_en), 32'h0);
    wr(pioxb_pkg::OFS_RES_SEL_B, 8'h80);
    wr(pioxb_pkg::OFS_OUT_MODE, 8'h00);
    settle();
    chk(32'(pad_oe[7:0]), 32'h0);
    $display("drive test done");
  endtask : t_drive
  task automatic t_route;
    wr(pioxb_pkg::OFS_SKIP_MASK, 8'h1C);
    wr(pioxb_pkg::OFS_RES_SEL_A, 8'h05);
    periph_drive <= 16'hFFFD;
    wr(pioxb_pkg::OFS_RES_SEL_B, 8'h81);
    settle();
    chk(32'(periph_routed), 32'h04C3);
    chk(32'({pad_oe[7:0], periph_in[1]}), 32'hA7);
    rd(pioxb_pkg::OFS_PORT_DATA);
    chk(32'(rdv), 32'hAC);
    wr(pioxb_pkg::OFS_RES_SEL_A, 8'h1E);
    periph_out <= 16'h5555;
    periph_drive <= 16'hFFFF;
    wr(pioxb_pkg::OFS_RES_SEL_B, 8'hBF);
    settle();
    chk(32'(periph_routed), 32'hFFFC);
    chk(32'(pad_oe), 32'h115542);
    $display("crossbar test done");
  endtask : t_route
  task automatic t_rereset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
  endtask : t_rereset
  task automatic t_unmapped;
    rd(8'h38);
    chk(32'({rdv, resp}), 32'(pioxb_pkg::RESP_SLVERR));
    wr(8'h38, 8'h5A);
    chk(32'(resp), 32'(pioxb_pkg::RESP_SLVERR));
    $display("unmapped test done");
  endtask : t_unmapped
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_analog();
    t_drive();
    t_route();
    t_rereset();
    t_unmapped();
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : test_port_io_cell_and_crossbar
`default_nettype wire
